// [design/temp_readout_consts.svh]
// Purpose: Constants for the temperature readout slave
// Assumes: ref_clk at 100 MHz
// Notes: Offsets, field positions, reset values and timing counts
`ifndef TEMP_READOUT_CONSTS_SVH
`define TEMP_READOUT_CONSTS_SVH
// Fixed upper nibble of the 7-bit slave address
`define ADDR_FIXED_HI 4'h9
// Pointer value of the temperature register
`define PTR_TEMP_VALUE 8'h00
// Reset values
`define TEMP_VALUE_RESET 16'h0000
`define PTR_RESET 8'h00
// Left-justified result: 12 bits at D15..D4, D3..D0 zero
`define TEMP_RESULT_LSB 4
`define TEMP_PAD_BITS 4'h0
// Bits in one bus byte
`define BYTE_BITS 4'h8
// Reference clock rate in kHz
`define REF_CLK_KHZ 100000
// Conversion period in ms, and the derived cycle count
`define CONV_PERIOD_MS 80
`define CONV_PERIOD_CYC (`CONV_PERIOD_MS * `REF_CLK_KHZ)
`endif

// [design/temp_readout_pkg.sv]
// Purpose: Types for the temperature readout slave
// Assumes: Nothing beyond the constants header
// Notes: Gray codes along address, ack, data, ack
package temp_readout_pkg;
    // Serial slave states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_ADDR_ACK = 3'h3,
        ST_RX = 3'h2,
        ST_RX_ACK = 3'h6,
        ST_TX = 3'h7,
        ST_TX_ACK = 3'h5
    } slave_state_t;
endpackage

// [design/temp_sensor_readout.sv]
// Purpose: Two-wire slave readout of a periodic temperature conversion
// Assumes: scl_in and sda_in synchronous to ref_clk, open-drain data line
// Notes: Only the temperature register is held here; other pointers read zero
`timescale 1ns/1ps
`include "temp_readout_consts.svh"

module temp_sensor_readout #(
    parameter int unsigned CONV_CYCLES = `CONV_PERIOD_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Two-wire bus, data line open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Address select straps
    input wire logic addr_select_bit2,
    input wire logic addr_select_bit1,
    input wire logic addr_select_bit0,
    // Converter handshake
    output logic conv_start,
    input wire logic adc_valid,
    input wire logic [11:0] adc_result,
    // Status
    output temp_readout_pkg::slave_state_t bus_state
);
    import temp_readout_pkg::*;

    localparam int CW = $clog2(CONV_CYCLES);

    // Refuse a period the counter cannot serve
    if (CONV_CYCLES < 2) begin : g_bad_period
        $error("CONV_CYCLES must be at least 2");
    end

    // Previous bus levels for edge detection
    logic scl_q_ff;
    logic sda_q_ff;
    // Slave state and byte handling
    slave_state_t state_ff;
    logic [3:0] bitcnt_ff;
    logic [7:0] shift_ff;
    logic rw_ff;
    logic first_ff;
    logic byte_sel_ff;
    logic [7:0] ptr_ff;
    logic [15:0] snap_ff;
    logic sda_oe_ff;
    logic sda_out_ff;
    // Conversion timer and result
    logic [CW-1:0] conv_cnt_ff;
    logic conv_start_ff;
    logic [15:0] temp_value_ff;

    // Bus events; 100 MHz sampling covers 400 kHz with wide margin
    wire scl_rise = scl_in & ~scl_q_ff;
    wire scl_fall = ~scl_in & scl_q_ff;
    wire bus_start = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
    wire bus_stop = scl_in & scl_q_ff & ~sda_q_ff & sda_in;
    wire byte_done = (bitcnt_ff == `BYTE_BITS);

    // Own 7-bit address from the fixed nibble and straps
    wire [6:0] own_addr = {`ADDR_FIXED_HI, addr_select_bit2, addr_select_bit1,
        addr_select_bit0};
    wire addr_hit = (shift_ff[7:1] == own_addr);

    // Register selected by the pointer; unheld pointers read zero
    wire [15:0] read_word = (ptr_ff == `PTR_TEMP_VALUE) ? temp_value_ff : 16'h0000;
    // Byte to send: MSB first, LSB second
    wire [7:0] tx_byte = byte_sel_ff ? snap_ff[7:0] : snap_ff[15:8];

    // Left-justified result word
    wire [15:0] result_word = {adc_result, `TEMP_PAD_BITS};

    // Edge history
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            scl_q_ff <= scl_in;
            sda_q_ff <= sda_in;
        end
    end

    // Slave state machine; never drives the clock, never starts a transfer
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= ST_IDLE;
            bitcnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            rw_ff <= 1'b0;
            first_ff <= 1'b0;
            byte_sel_ff <= 1'b0;
            ptr_ff <= `PTR_RESET;
            snap_ff <= `TEMP_VALUE_RESET;
            sda_oe_ff <= 1'b0;
        end else if (bus_start) begin
            // Start, or repeated start, always re-arms address capture
            state_ff <= ST_ADDR;
            bitcnt_ff <= 4'h0;
            sda_oe_ff <= 1'b0;
        end else if (bus_stop) begin
            // Stop ends any transfer and frees the line
            state_ff <= ST_IDLE;
            sda_oe_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    // Wait for a start
                    sda_oe_ff <= 1'b0;
                end
                ST_ADDR, ST_RX: begin
                    if (scl_rise && !byte_done) begin
                        // Sample on clock high, MSB first
                        shift_ff <= {shift_ff[6:0], sda_in};
                        bitcnt_ff <= bitcnt_ff + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        bitcnt_ff <= 4'h0;
                        if (state_ff == ST_RX) begin
                            // Every received byte is acked
                            sda_oe_ff <= 1'b1;
                            state_ff <= ST_RX_ACK;
                        end else if (addr_hit) begin
                            sda_oe_ff <= 1'b1;
                            rw_ff <= shift_ff[0];
                            state_ff <= ST_ADDR_ACK;
                        end else begin
                            // Another slave is addressed
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_ff) begin
                            // Read: freeze the word so both bytes match
                            snap_ff <= read_word;
                            shift_ff <= {(read_word[14:8]), 1'b0};
                            sda_oe_ff <= ~read_word[15];
                            byte_sel_ff <= 1'b1;
                            bitcnt_ff <= 4'h1;
                            state_ff <= ST_TX;
                        end else begin
                            // Write: next byte is the pointer
                            sda_oe_ff <= 1'b0;
                            first_ff <= 1'b1;
                            state_ff <= ST_RX;
                        end
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        sda_oe_ff <= 1'b0;
                        first_ff <= 1'b0;
                        // First data byte sets the pointer; later ones are dropped
                        if (first_ff) begin
                            ptr_ff <= shift_ff;
                        end
                        state_ff <= ST_RX;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (byte_done) begin
                            // Release for the master's ack bit
                            sda_oe_ff <= 1'b0;
                            state_ff <= ST_TX_ACK;
                        end else begin
                            sda_oe_ff <= ~shift_ff[7];
                            shift_ff <= {shift_ff[6:0], 1'b0};
                            bitcnt_ff <= bitcnt_ff + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise && sda_in) begin
                        // Nack: stop driving until the next start
                        sda_oe_ff <= 1'b0;
                        state_ff <= ST_IDLE;
                    end else if (scl_fall) begin
                        // Ack: send the other byte; words repeat
                        shift_ff <= {tx_byte[6:0], 1'b0};
                        sda_oe_ff <= ~tx_byte[7];
                        byte_sel_ff <= ~byte_sel_ff;
                        bitcnt_ff <= 4'h1;
                        state_ff <= ST_TX;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                    sda_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    // Free-running conversion timer; the bus has no path into it
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            conv_cnt_ff <= '0;
            conv_start_ff <= 1'b0;
        end else begin
            conv_start_ff <= (conv_cnt_ff == '0);
            if (conv_cnt_ff == '0) begin
                conv_cnt_ff <= CW'(CONV_CYCLES - 1);
            end else begin
                conv_cnt_ff <= conv_cnt_ff - 1'b1;
            end
        end
    end

    // Result register only changes on a finished conversion
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            temp_value_ff <= `TEMP_VALUE_RESET;
        end else if (adc_valid) begin
            temp_value_ff <= result_word;
        end
    end

    // Open drain: the driven level is always low
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sda_out_ff <= 1'b0;
        end else begin
            sda_out_ff <= 1'b0;
        end
    end

    assign sda_out = sda_out_ff;
    assign sda_oe = sda_oe_ff;
    assign conv_start = conv_start_ff;
    assign bus_state = state_ff;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    // Ack phase steps
    sequence s_addr_seen;
        scl_fall && state_ff == ST_ADDR && byte_done && addr_hit;
    endsequence
    sequence s_ack_driven;
        sda_oe_ff && state_ff == ST_ADDR_ACK;
    endsequence

    chk_start_arms: assert property (bus_start |=> state_ff == ST_ADDR && !sda_oe_ff)
        else $error("start did not arm address capture");
    chk_stop_frees: assert property (bus_stop |=> state_ff == ST_IDLE && !sda_oe_ff)
        else $error("stop did not free the bus");
    chk_addr_ack: assert property (s_addr_seen and !bus_start and !bus_stop
        |=> s_ack_driven)
        else $error("matching address not acked");
    chk_addr_miss: assert property (scl_fall && state_ff == ST_ADDR && byte_done
        && !addr_hit && !bus_start && !bus_stop |=> state_ff == ST_IDLE)
        else $error("foreign address not ignored");
    chk_ack_hold: assert property ((state_ff == ST_ADDR_ACK || state_ff == ST_RX_ACK)
        && scl_in && !scl_fall |-> sda_oe_ff)
        else $error("ack released during clock high");
    chk_nack_release: assert property (state_ff == ST_TX_ACK && scl_rise && sda_in
        && !bus_start && !bus_stop |=> !sda_oe_ff [*2])
        else $error("data still driven after nack");
    chk_ptr_load: assert property (state_ff == ST_RX_ACK && scl_fall && first_ff
        && !bus_start && !bus_stop |=> ptr_ff == $past(shift_ff))
        else $error("pointer not taken from first byte");
    // Read snapshot is taken as the address ack ends, so both bytes match
    chk_tx_snap: assert property (state_ff == ST_ADDR_ACK && scl_fall && rw_ff
        && !bus_start && !bus_stop
        |=> state_ff == ST_TX && snap_ff == $past(read_word))
        else $error("read word not frozen at address ack");
    chk_conv_period: assert property (conv_start_ff |=>
        conv_cnt_ff == CW'(CONV_CYCLES - 2))
        else $error("conversion period not reloaded");
    chk_conv_steady: assert property (conv_cnt_ff != '0 |=>
        conv_cnt_ff == $past(conv_cnt_ff) - 1'b1 && !conv_start_ff)
        else $error("conversion timer disturbed");
    chk_result_store: assert property (adc_valid |=>
        temp_value_ff == {$past(adc_result), 4'h0})
        else $error("result not stored left-justified");
    chk_hold_prev: assert property (!adc_valid |=> $stable(temp_value_ff))
        else $error("temperature changed without a result");
endmodule

// [testbench/bus_master_model.sv]
// Purpose: Two-wire bus master model that starts every transfer
// Assumes: Data line has a pull-up; it is low while any party pulls it
// Notes: Each clock level lasts at least HALF cycles, well above the slave's minimum
`timescale 1ns/1ps
module bus_master_model #(
    parameter int HALF = 4
) (
    // Clock
    input wire logic ref_clk,
    // Resolved data line
    input wire logic sda_w,
    // Driven lines, high means released
    output logic scl,
    output logic sda
);
    // Bus rests high
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Step just past the edge so inputs never race the sampling edge
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Start: data falls while clock high
    task automatic start();
        sda = 1'b1;
        cyc(HALF);
        scl = 1'b1;
        cyc(HALF);
        sda = 1'b0;
        cyc(HALF);
        scl = 1'b0;
        cyc(HALF);
    endtask
    // Stop: data rises while clock high
    task automatic stop();
        sda = 1'b0;
        cyc(HALF);
        scl = 1'b1;
        cyc(HALF);
        sda = 1'b1;
        cyc(HALF);
    endtask
    // One clock pulse; v is the level at the rise, st says it held all high phase
    task automatic pulse(input logic d, output logic v, output logic st);
        sda = d;
        cyc(HALF);
        scl = 1'b1;
        v = sda_w;
        st = 1'b1;
        repeat (HALF) begin
            cyc(1);
            st &= (sda_w === v);
        end
        scl = 1'b0;
    endtask
    // Byte out MSB first, then release for the slave's ack
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic v, st;
        for (int i = 7; i >= 0; i--) begin
            pulse(b[i], v, st);
        end
        pulse(1'b1, v, st);
        ack = (v === 1'b0) && st;
    endtask
    // Byte in, then ack or nack as the master decides
    task automatic rbyte(input logic nack, output logic [7:0] b, output logic ok);
        logic st, v;
        ok = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            pulse(1'b1, b[i], st);
            ok &= st;
        end
        // Ack slot level goes to a scratch bit so the data LSB survives
        pulse(nack, v, st);
    endtask
endmodule

// [testbench/temp_sensor_i2c_readout_tb.sv]
// Purpose: Self-checking bench for the temperature readout slave
// Assumes: Converter answers LAT cycles after each start once adc_on is set
// Notes: Short conversion period keeps the run brief
`timescale 1ns/1ps
module temp_sensor_i2c_readout_tb;
    import temp_readout_pkg::*;
    localparam int CONV = 400;
    localparam int LAT = 10;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic scl, msda, sda_w, sda_out, sda_oe, conv_start;
    logic [2:0] straps = 3'h0;
    logic adc_valid = 1'b0;
    logic adc_on = 1'b0;
    logic [11:0] adc_result = 12'h000;
    logic [11:0] adc_val = 12'h000;
    logic [11:0] codes [3] = '{12'h190, 12'h8A5, 12'h7FF};
    slave_state_t bus_state;
    int num_errors = 0;
    int compares = 0;
    int gap = 0;
    logic seen_one = 1'b0;
    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;
    // Open-drain data line with pull-up
    assign sda_w = msda & (sda_oe ? sda_out : 1'b1);
    bus_master_model #(.HALF(4)) m (.ref_clk(ref_clk), .sda_w(sda_w), .scl(scl), .sda(msda));
    temp_sensor_readout #(.CONV_CYCLES(CONV)) dut (
        .ref_clk(ref_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe(sda_oe), .addr_select_bit2(straps[2]), .addr_select_bit1(straps[1]),
        .addr_select_bit0(straps[0]), .conv_start(conv_start), .adc_valid(adc_valid),
        .adc_result(adc_result), .bus_state(bus_state));
    // Converter stand-in; result bus shows garbage outside the valid pulse
    always @(posedge ref_clk) begin
        if (conv_start === 1'b1 && adc_on) begin
            repeat (LAT) @(posedge ref_clk);
            #1 adc_result = adc_val;
            adc_valid = 1'b1;
            m.cyc(1);
            adc_valid = 1'b0;
            adc_result = ~adc_val;
        end
    end
    // Conversion spacing must hold whatever the bus does
    always @(posedge ref_clk) begin
        if (!nrst) begin
            gap = 0;
            seen_one = 1'b0;
        end else begin
            gap++;
            if (conv_start === 1'b1) begin
                if (seen_one) check(16'(gap), 16'(CONV));
                seen_one = 1'b1;
                gap = 0;
            end
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (num_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Wait until a fresh result sits in the register
    task automatic wait_conv();
        @(negedge adc_valid);
        m.cyc(2);
    endtask
    // Read two bytes acked then nacked; slave must let go after the nack
    task automatic read_word(output logic [15:0] w);
        logic a, s1, s2;
        m.start();
        m.wbyte({4'h9, straps, 1'b1}, a);
        check(16'(a), 16'h1);
        m.rbyte(1'b0, w[15:8], s1);
        m.rbyte(1'b1, w[7:0], s2);
        check(16'({s1, s2, sda_oe, bus_state === ST_IDLE}), 16'hD);
        m.stop();
    endtask
    // Write address, pointer, then n extra data bytes
    task automatic write_ptr(input logic [7:0] adr, input logic [7:0] ptr, input int n,
                             output logic acks);
        logic a;
        m.start();
        m.wbyte(adr, acks);
        m.wbyte(ptr, a);
        acks &= a;
        repeat (n) begin
            m.wbyte(8'hA5, a);
            acks &= a;
        end
        m.stop();
    endtask
    // Reset levels, then the reset value before any result lands
    task automatic t_reset();
        logic [15:0] w;
        check(16'({sda_oe, conv_start, bus_state}), 16'h0);
        nrst = 1'b1;
        m.cyc(8);
        read_word(w);
        check(w, 16'h0000);
        adc_on = 1'b1;
    endtask
    // Every strap setting: own address acked, neighbour ignored
    task automatic t_addr();
        logic ok;
        for (int s = 0; s < 8; s++) begin
            straps = 3'(s);
            write_ptr({4'h9, 3'(s), 1'b0}, 8'h00, 0, ok);
            check(16'(ok), 16'h1);
            write_ptr({4'h9, 3'(s) ^ 3'h1, 1'b0}, 8'h00, 0, ok);
            check(16'(ok), 16'h0);
        end
    endtask
    // Positive, negative and top codes come back left-justified
    task automatic t_read();
        logic [15:0] w;
        straps = 3'h5;
        for (int i = 0; i < 3; i++) begin
            adc_val = codes[i];
            wait_conv();
            read_word(w);
            check(w, {codes[i], 4'h0});
            // The first code is 25 degrees once divided by 16
            if (i == 0) check(16'(w[15:4]) / 16'h0010, 16'h0019);
        end
    endtask
    // Pointer write, repeated start, then a read that wraps past two bytes
    task automatic t_rep();
        logic a1, a2, a3, s1, s2, s3, s4;
        logic [7:0] b1, b2, b3, b4;
        m.start();
        m.wbyte({4'h9, straps, 1'b0}, a1);
        m.wbyte(8'h00, a2);
        m.start();
        m.wbyte({4'h9, straps, 1'b1}, a3);
        check(16'({a1, a2, a3}), 16'h0007);
        m.rbyte(1'b0, b1, s1);
        m.rbyte(1'b0, b2, s2);
        m.rbyte(1'b0, b3, s3);
        m.rbyte(1'b1, b4, s4);
        m.stop();
        check({b1, b2}, 16'hC400);
        check({b3, b4}, 16'hC400);
        check(16'({s1, s2, s3, s4}), 16'h000F);
    endtask
    // Other pointer reads zero; data bytes acked but the register is read-only
    task automatic t_ptr();
        logic ok;
        logic [15:0] w;
        write_ptr({4'h9, straps, 1'b0}, 8'h03, 2, ok);
        check(16'(ok), 16'h1);
        read_word(w);
        check(w, 16'h0000);
        write_ptr({4'h9, straps, 1'b0}, 8'h00, 2, ok);
        read_word(w);
        check(w, {codes[2], 4'h0});
    endtask
    // New result lands mid-read: old value read, new one next time
    task automatic t_mid();
        logic [15:0] w;
        adc_val = 12'h321;
        wait_conv();
        adc_val = 12'hC40;
        m.cyc(CONV - 120);
        read_word(w);
        check(w, 16'h3210);
        read_word(w);
        check(w, 16'hC400);
    endtask
    // Hang guard: the tests need about 70 us, this allows roughly three times that
    initial begin
        #200000;
        num_errors++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        #1;
        t_reset();
        t_addr();
        t_read();
        t_ptr();
        t_mid();
        t_rep();
        complete_run();
    end
endmodule
